/* logic/sysref_cal_top.sv */
// sysref capture/alignment, nco phase reset and converter calibration sequencing
`timescale 1ns/10ps
`default_nettype none
`include "sysref_cal_defs.svh"

module sysref_cal_top #(
    parameter int LMFC_CYCLES = `LMFC_CYCLES,
    parameter int FG_CYC = `FG_CAL_CYCLES,
    parameter int FG_T_CYC = `FG_CAL_TIMING_CYCLES,
    parameter int FGB_CYC = `FG_CAL_BG_CYCLES,
    parameter int FGB_T_CYC = `FG_CAL_BG_TIMING_CYCLES,
    parameter int BG_ROUND_CYC = `BG_ROUND_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sysref_in,
    input wire logic sync_n,
    input wire logic [11:0] adc_raw,
    input wire sysref_cal_pkg::iq_in_t ddc_in,
    output sysref_cal_pkg::sample_out_t sample_out,
    output logic nco_phase_reset,
    output logic link_enable,
    output logic [4:0] core_online,
    output logic cal_busy
);
    import sysref_cal_pkg::*;

    localparam int NUM_CORES = 5;
    // one core slot of a full background round; all five slots share the fixed rate
    localparam int ROT_CYC = BG_ROUND_CYC / NUM_CORES;

    state_t st;
    state_t n;
    logic cap_en;
    logic cap_rise;
    logic cap_dirty;
    logic wr_go;
    logic [7:0] wd;
    logic clr_seen;
    logic clr_marg;
    logic trig;
    logic lmfc_wrap;
    logic sync_release;
    logic [5:0] factor;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [5:0] dec_factor(input logic [2:0] sel);
        unique case (sel)
            3'h1: dec_factor = 6'h04;
            3'h2: dec_factor = 6'h08;
            3'h3: dec_factor = 6'h0A;
            3'h4: dec_factor = 6'h10;
            3'h5: dec_factor = 6'h14;
            3'h6: dec_factor = 6'h20;
            default: dec_factor = 6'h01;
        endcase
    endfunction

    function automatic logic [31:0] fg_limit(input logic bg, input logic tcal);
        if (bg) begin
            fg_limit = tcal ? 32'(FGB_T_CYC) : 32'(FGB_CYC);
        end else begin
            fg_limit = tcal ? 32'(FG_T_CYC) : 32'(FG_CYC);
        end
    endfunction

    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] idx);
        read_reg = 8'h00;
        case (idx)
            `IDX_CLKGEN: begin
                read_reg[`BIT_RCVR_ON] = s.rcvr_on;
                read_reg[`BIT_PROC_ON] = s.proc_on;
            end
            `IDX_CAPTURE: begin
                read_reg[`BIT_SEEN] = s.seen;
                read_reg[`BIT_MARGINAL] = s.marginal;
            end
            `IDX_DELAY: read_reg[3:0] = s.delay_sel;
            `IDX_CAL: read_reg[`BIT_CAL_BUSY] = s.cal == CAL_FG;
            `IDX_BGCAL: begin
                read_reg[`BIT_BG_SELECT] = s.bg_select;
                read_reg[`BIT_CAL_CONTINUOUS] = s.cal_continuous;
                read_reg[`LSB_OFFLINE_CORE +: 3] = s.offline_core;
            end
            `IDX_DATAPATH: begin
                read_reg[`LSB_DEC_SEL +: 3] = s.dec_sel;
                read_reg[`BIT_TIMING_CAL] = s.timing_cal_on;
                read_reg[`BIT_LINK_ENABLE] = s.link_on;
            end
            default: read_reg = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = st;
        wr_go = st.ap_valid && st.ap_write;
        wd = hwdata[7:0];
        clr_seen = wr_go && st.ap_idx == `IDX_CLKGEN && wd[`BIT_SEEN_CLEAR];
        clr_marg = wr_go && st.ap_idx == `IDX_CLKGEN && wd[`BIT_MARGINAL_CLEAR];
        trig = wr_go && st.ap_idx == `IDX_CAL && wd[`BIT_CAL_TRIGGER];
        cap_en = st.rcvr_on && st.proc_on;
        cap_rise = cap_en && st.cap_hist[0] && !st.cap_hist[1];
        // a one-cycle pulse means the delayed edge sat on the sampling instant
        cap_dirty = cap_en && st.cap_hist == 3'b010;
        lmfc_wrap = st.lmfc_cnt == 8'(LMFC_CYCLES - 1);
        sync_release = st.syncn_sr[1] && !st.syncn_prev;
        factor = dec_factor(st.dec_sel);

        // pin synchronisers
        n.sysref_sr = {st.sysref_sr[0], sysref_in};
        n.syncn_sr = {st.syncn_sr[0], sync_n};
        n.syncn_prev = st.syncn_sr[1];

        // delay line and capture
        n.dly_line = cap_en ? {st.dly_line[14:0], st.sysref_sr[1]} : 16'h0000;
        n.cap_hist = cap_en ? {st.cap_hist[1:0], st.dly_line[st.delay_sel]} : 3'h0;
        n.seen = cap_rise || (st.seen && !clr_seen);
        n.marginal = cap_dirty || (st.marginal && !clr_marg);

        // register writes
        if (wr_go) begin
            case (st.ap_idx)
                `IDX_CLKGEN: begin
                    n.rcvr_on = wd[`BIT_RCVR_ON];
                    n.proc_on = wd[`BIT_PROC_ON];
                end
                `IDX_DELAY: n.delay_sel = wd[3:0];
                `IDX_BGCAL: begin
                    n.bg_select = wd[`BIT_BG_SELECT];
                    n.cal_continuous = wd[`BIT_CAL_CONTINUOUS];
                end
                `IDX_DATAPATH: begin
                    n.dec_sel = wd[`LSB_DEC_SEL +: 3];
                    n.timing_cal_on = wd[`BIT_TIMING_CAL];
                    n.link_on = wd[`BIT_LINK_ENABLE];
                end
                default: n.ap_valid = st.ap_valid;
            endcase
        end

        // multiframe clock, realigned on every captured sysref edge
        if (cap_rise || lmfc_wrap) begin
            n.lmfc_cnt = 8'h00;
        end else begin
            n.lmfc_cnt = st.lmfc_cnt + 8'h01;
        end

        // ila starts at the first multiframe boundary after sync release
        n.nco_reset = 1'b0;
        if (!st.link_on || !st.syncn_sr[1]) begin
            n.ila_pending = 1'b0;
        end else if (sync_release) begin
            n.ila_pending = 1'b1;
        end else if (st.ila_pending && lmfc_wrap) begin
            n.ila_pending = 1'b0;
            n.nco_reset = st.dec_sel != 3'h0;
        end

        // calibration sequencer
        unique case (st.cal)
            CAL_IDLE: begin
                n.cal_cnt = 32'h0000_0000;
            end
            CAL_FG: begin
                // compare with >= so a bound shortened mid-run still ends the calibration
                if (st.cal_cnt >= fg_limit(st.bg_select && st.cal_continuous,
                                           st.timing_cal_on) - 32'h0000_0001) begin
                    n.cal = (st.bg_select && st.cal_continuous) ? CAL_BG : CAL_IDLE;
                    n.cal_cnt = 32'h0000_0000;
                end else begin
                    n.cal_cnt = st.cal_cnt + 32'h0000_0001;
                end
            end
            CAL_BG: begin
                if (!(st.bg_select && st.cal_continuous)) begin
                    n.cal = CAL_IDLE;
                end else if (st.rot_cnt == 32'(ROT_CYC - 1)) begin
                    n.rot_cnt = 32'h0000_0000;
                    n.offline_core = (st.offline_core == 3'(NUM_CORES - 1)) ? 3'h0 :
                                     st.offline_core + 3'h1;
                end else begin
                    n.rot_cnt = st.rot_cnt + 32'h0000_0001;
                end
            end
        endcase
        // the trigger bit is never stored, so it always reads back as zero
        if (trig) begin
            n.cal = CAL_FG;
            n.cal_cnt = 32'h0000_0000;
            n.rot_cnt = 32'h0000_0000;
            n.offline_core = 3'h0;
        end
        // the swap is one edge: the returning core comes online as the next leaves
        n.core_on = (n.cal == CAL_BG) ? 5'h1F & ~(5'h01 << n.offline_core) :
                    `RST_CORE_MASK;
        n.cal_busy = n.cal == CAL_FG;

        // output samples
        n.dec_cnt = (st.dec_cnt >= factor - 6'h01) ? 6'h00 : st.dec_cnt + 6'h01;
        if (st.cal == CAL_FG) begin
            n.sample_out.valid = 1'b0;
            n.sample_out.iq = 1'b0;
            n.sample_out.i = `CAL_HOLD_CODE;
            n.sample_out.q = `CAL_HOLD_CODE;
        end else if (st.dec_sel == 3'h0 || factor == 6'h01) begin
            n.sample_out.valid = 1'b1;
            n.sample_out.iq = 1'b0;
            n.sample_out.i = {3'h0, adc_raw};
            n.sample_out.q = 15'h0000;
        end else begin
            n.sample_out.valid = st.dec_cnt == 6'h00;
            n.sample_out.iq = 1'b1;
            if (st.dec_cnt == 6'h00) begin
                n.sample_out.i = ddc_in.i;
                n.sample_out.q = ddc_in.q;
            end
        end

        // ahb-lite slave: zero wait states, always OKAY
        n.ap_valid = hsel && htrans[1] && hready;
        n.ap_write = hwrite;
        n.ap_idx = haddr[9:2];
        n.hreadyout = 1'b1;
        n.hresp = 1'b0;
        // read data comes from the next state, so a write just before is seen
        if (hsel && htrans[1] && hready && !hwrite) begin
            n.hrdata = {24'h00_0000, read_reg(n, haddr[9:2])};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.delay_sel <= `RST_DELAY_SEL;
            st.dec_sel <= `RST_DEC_SEL;
            st.core_on <= `RST_CORE_MASK;
        end else begin
            st <= n;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = st.hresp;
    assign sample_out = st.sample_out;
    assign nco_phase_reset = st.nco_reset;
    assign link_enable = st.link_on;
    assign core_online = st.core_on;
    assign cal_busy = st.cal_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence sysref_arrives_undelayed;
        cap_en && st.delay_sel == 4'h0 && !st.sysref_sr[1] ##1
        st.sysref_sr[1] && cap_en && st.delay_sel == 4'h0;
    endsequence

    sequence ila_boundary;
        st.link_on && st.syncn_sr[1] && st.ila_pending && lmfc_wrap && !sync_release;
    endsequence

    AST_DELAY_ZERO: assert property (sysref_arrives_undelayed ##1 cap_en |=> st.cap_hist[0])
        else $error("undelayed sysref edge not captured two cycles later");
    AST_SEEN_SET: assert property (cap_rise |=> st.seen && st.lmfc_cnt == 8'h00)
        else $error("captured edge did not set seen and realign lmfc");
    AST_MARG_SET: assert property (cap_dirty |=> st.marginal)
        else $error("marginal capture did not set flag");
    AST_SEEN_CLR: assert property (clr_seen && !cap_rise |=> !st.seen)
        else $error("seen clear ignored");
    AST_MARG_CLR: assert property (clr_marg && !cap_dirty |=> !st.marginal)
        else $error("marginal clear ignored");
    AST_ENABLES: assert property (!cap_en && !st.seen && !clr_seen |=> !st.seen [*2])
        else $error("seen set while capture disabled");
    AST_NCO_ILA: assert property (ila_boundary |=> st.nco_reset == ($past(st.dec_sel) != 3'h0))
        else $error("nco reset wrong at ila start");
    AST_BYPASS: assert property (st.cal != CAL_FG && st.dec_sel == 3'h0 |=>
        st.sample_out.valid && !st.sample_out.iq && st.sample_out.i[11:0] == $past(adc_raw))
        else $error("bypass sample missing or wrong");
    AST_DDC_GAP: assert property (st.sample_out.valid && st.sample_out.iq &&
        st.dec_sel != 3'h0 && factor != 6'h01 && st.cal != CAL_FG |=> !st.sample_out.valid)
        else $error("ddc output faster than decimation");
    AST_FG_HOLD: assert property (st.cal == CAL_FG |=>
        !st.sample_out.valid && st.sample_out.i == `CAL_HOLD_CODE)
        else $error("output not held during calibration");
    AST_TRIGGER: assert property (trig |=> st.cal == CAL_FG && st.cal_cnt == 32'h0 &&
        st.cal_busy ##1 st.cal_cnt == 32'h1 || st.cal != CAL_FG)
        else $error("trigger did not start calibration from zero");
    AST_FG_BOUND: assert property (st.cal == CAL_FG |->
        st.cal_cnt < fg_limit(st.bg_select && st.cal_continuous, st.timing_cal_on))
        else $error("foreground calibration overran its bound");
    AST_RESTART: assert property (st.cal == CAL_BG && trig |=>
        st.cal == CAL_FG && st.offline_core == 3'h0 && st.rot_cnt == 32'h0)
        else $error("trigger did not reset calibration control");
    AST_BG_CORES: assert property (st.cal == CAL_BG |->
        $countones(st.core_on) == 4 && !st.core_on[st.offline_core])
        else $error("background mode core set wrong");
    AST_BG_RATE: assert property (st.cal == CAL_BG && st.rot_cnt != 32'(ROT_CYC - 1) &&
        !trig |=> $stable(st.offline_core))
        else $error("offline core moved off schedule");

endmodule
`default_nettype wire

/* logic/sysref_cal_defs.svh */
// register indices, field positions, reset values and cycle counts of the sysref/calibration block
`ifndef SYSREF_CAL_DEFS_SVH
`define SYSREF_CAL_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_CLKGEN 8'h30
`define IDX_CAPTURE 8'h31
`define IDX_DELAY 8'h32
`define IDX_CAL 8'h50
`define IDX_BGCAL 8'h57
`define IDX_DATAPATH 8'h60

// sysref_clock_gen_control fields
`define BIT_RCVR_ON 7
`define BIT_PROC_ON 6
`define BIT_SEEN_CLEAR 5
`define BIT_MARGINAL_CLEAR 4
// sysref_capture_status fields
`define BIT_SEEN 7
`define BIT_MARGINAL 6
// calibration_control fields
`define BIT_CAL_TRIGGER 3
`define BIT_CAL_BUSY 0
// background_cal_control fields
`define BIT_BG_SELECT 0
`define BIT_CAL_CONTINUOUS 1
`define LSB_OFFLINE_CORE 4
// datapath_config fields
`define LSB_DEC_SEL 0
`define BIT_TIMING_CAL 3
`define BIT_LINK_ENABLE 4

// reset values and the sample code held during foreground calibration
`define RST_DELAY_SEL 4'h0
`define RST_DEC_SEL 3'h0
`define RST_CORE_MASK 5'h0F
`define CAL_HOLD_CODE 15'h0000

// foreground/background calibration lengths and the lmfc period in device clock cycles
`define FG_CAL_CYCLES 102000000
`define FG_CAL_TIMING_CYCLES 227000000
`define FG_CAL_BG_CYCLES 127500000
`define FG_CAL_BG_TIMING_CYCLES 283750000
`define BG_ROUND_CYCLES 816000000
`define LMFC_CYCLES 32

`endif

/* logic/sysref_cal_pkg.sv */
// types shared by the sysref alignment and calibration block
package sysref_cal_pkg;

    typedef enum logic [1:0] {CAL_IDLE, CAL_FG, CAL_BG} cal_state_t;

    typedef struct packed {
        logic [14:0] i;
        logic [14:0] q;
    } iq_in_t;

    typedef struct packed {
        logic valid;
        logic iq;
        logic [14:0] i;
        logic [14:0] q;
    } sample_out_t;

    typedef struct packed {
        logic [1:0] sysref_sr;
        logic [1:0] syncn_sr;
        logic syncn_prev;
        logic [15:0] dly_line;
        logic [2:0] cap_hist;
        logic rcvr_on;
        logic proc_on;
        logic [3:0] delay_sel;
        logic seen;
        logic marginal;
        logic [2:0] dec_sel;
        logic timing_cal_on;
        logic link_on;
        logic bg_select;
        logic cal_continuous;
        cal_state_t cal;
        logic [31:0] cal_cnt;
        logic [31:0] rot_cnt;
        logic [2:0] offline_core;
        logic [7:0] lmfc_cnt;
        logic ila_pending;
        logic [5:0] dec_cnt;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_idx;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        sample_out_t sample_out;
        logic nco_reset;
        logic [4:0] core_on;
        logic cal_busy;
    } state_t;

endpackage

/* tb/sysref_link_partner.sv */
// model of the sysref source and the link receiver that drives the sync request
`timescale 1ns/10ps
`default_nettype none
module sysref_link_partner #(
    parameter int PERIOD = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sysref_run,
    input wire logic narrow,
    input wire logic sync_release,
    output logic sysref_in,
    output logic sync_n
);
    logic [7:0] phase;

    ////////////////////////////////////////////////////////////////////////////////
    // period is twice the lmfc so edges always land on the same lmfc phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 8'h00;
            sysref_in <= 1'b0;
            sync_n <= 1'b0;
        end else begin
            phase <= (phase == 8'(PERIOD - 1)) ? 8'h00 : phase + 8'h01;
            // narrow pulse is a deliberately marginal capture, only on request
            sysref_in <= sysref_run && (narrow ? phase == 8'h00 : phase < 8'h04);
            sync_n <= sync_release;
        end
    end
endmodule
`default_nettype wire

/* tb/sysref_align_and_calibration_tb.sv */
// self-checking testbench for the sysref alignment and calibration block
`timescale 1ns/10ps
`default_nettype none
module sysref_align_and_calibration_tb;
    import sysref_cal_pkg::*;
    localparam int FG = 40;
    localparam int FGT = 60;
    localparam int FGB = 50;
    localparam int ROUND = 100;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [11:0] adc_raw = 12'h000;
    iq_in_t ddc_in = '0;
    sample_out_t sample_out;
    logic nco_phase_reset;
    logic link_enable;
    logic [4:0] core_online;
    logic cal_busy;
    logic sysref_in;
    logic sync_n;
    logic sysref_run = 1'b0;
    logic narrow = 1'b0;
    logic sync_release = 1'b0;
    logic [4:0] c0;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int busy_len = 0;
    int n;
    logic [31:0] rd;

    sysref_cal_top #(.LMFC_CYCLES(8), .FG_CYC(FG), .FG_T_CYC(FGT), .FGB_CYC(FGB),
        .FGB_T_CYC(70), .BG_ROUND_CYC(ROUND)) u_sysref_cal_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sysref_in(sysref_in),
        .sync_n(sync_n), .adc_raw(adc_raw), .ddc_in(ddc_in), .sample_out(sample_out),
        .nco_phase_reset(nco_phase_reset), .link_enable(link_enable),
        .core_online(core_online), .cal_busy(cal_busy));

    sysref_link_partner #(.PERIOD(16)) u_sysref_link_partner (
        .hclk(hclk), .hresetn(hresetn), .sysref_run(sysref_run), .narrow(narrow),
        .sync_release(sync_release), .sysref_in(sysref_in), .sync_n(sync_n));

    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cal_busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize();
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask

    // single word transfer; waits on hready rather than assuming zero wait
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic stop_clear(input logic [31:0] v);
        sysref_run <= 1'b0;
        narrow <= 1'b0;
        tick(30);
        ahb(1'b1, 32'hC0, v, rd);
    endtask

    task automatic wait_idle();
        n = 0;
        while (cal_busy === 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(32'(core_online), 32'h0F);
        check(32'(cal_busy), 32'h0);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b0, 32'hC0, 32'h0, rd);
        check(rd, 32'h0);
    endtask

    task automatic t_sysref();
        ahb(1'b1, 32'hC0, 32'h80, rd);
        sysref_run <= 1'b1;
        tick(40);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h00);
        ahb(1'b1, 32'hC0, 32'hC0, rd);
        tick(40);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h80);
        stop_clear(32'hE0);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h00);
        ahb(1'b0, 32'hC0, 32'h0, rd);
        check(rd, 32'hC0);
        ahb(1'b1, 32'hC8, 32'h0F, rd);
        ahb(1'b0, 32'hC8, 32'h0, rd);
        check(rd, 32'h0F);
        sysref_run <= 1'b1;
        tick(60);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h80);
        narrow <= 1'b1;
        tick(40);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'hC0);
        stop_clear(32'hD0);
        ahb(1'b0, 32'hC4, 32'h0, rd);
        check(rd, 32'h80);
    endtask

    // inside the loop the delay only grows one step at a time, so a pulse is stretched, never cut short
    task automatic t_sweep();
        int lo = 99;
        int hi = 0;
        sysref_run <= 1'b1;
        ahb(1'b1, 32'hC8, 32'h0, rd);
        tick(40);
        for (int d = 0; d < 16; d++) begin
            ahb(1'b1, 32'hC8, 32'(d), rd);
            ahb(1'b1, 32'hC0, 32'hF0, rd);
            tick(40);
            ahb(1'b0, 32'hC4, 32'h0, rd);
            check(rd, 32'h80);
            if (rd == 32'h80) begin
                lo = (d < lo) ? d : lo;
                hi = d;
            end
        end
        ahb(1'b1, 32'hC8, 32'((lo + hi) / 2), rd);
        ahb(1'b0, 32'hC8, 32'h0, rd);
        check(rd, 32'h07);
        stop_clear(32'hF0);
    endtask

    task automatic t_bypass();
        ahb(1'b1, 32'h180, 32'h0, rd);
        adc_raw <= 12'hA5C;
        tick(1);
        check(32'(sample_out), {1'b1, 1'b0, 3'h0, 12'hA5C, 15'h0});
        adc_raw <= 12'h5A3;
        tick(1);
        check(32'(sample_out), {1'b1, 1'b0, 3'h0, 12'h5A3, 15'h0});
    endtask

    task automatic t_ddc();
        int f[6] = '{4, 8, 10, 16, 20, 32};
        ddc_in <= '{i: 15'h1234, q: 15'h0ABC};
        for (int k = 0; k < 6; k++) begin
            ahb(1'b1, 32'h180, 32'(k + 1), rd);
            tick(40);
            n = 0;
            for (int c = 0; c < 4 * f[k]; c++) begin
                tick(1);
                n += (sample_out === {1'b1, 1'b1, 15'h1234, 15'h0ABC}) ? 1 : 0;
            end
            check(32'(n), 32'h4);
        end
    endtask

    task automatic count_nco();
        n = 0;
        repeat (40) begin
            tick(1);
            n += (nco_phase_reset === 1'b1) ? 1 : 0;
        end
    endtask

    task automatic t_ila();
        ahb(1'b1, 32'h180, 32'h11, rd);
        tick(1);
        check(32'(link_enable), 32'h1);
        sync_release <= 1'b1;
        count_nco();
        check(32'(n), 32'h1);
        sync_release <= 1'b0;
        ahb(1'b1, 32'h180, 32'h10, rd);
        tick(5);
        sync_release <= 1'b1;
        count_nco();
        check(32'(n), 32'h0);
    endtask

    task automatic cal(input logic [31:0] dp, input int len);
        ahb(1'b1, 32'h180, dp, rd);
        busy_len = 0;
        ahb(1'b1, 32'h140, 32'h8, rd);
        check(32'(hresp), 32'h0);
        tick(2);
        check(32'({sample_out.valid, sample_out.i, sample_out.q}), 32'h0);
        ahb(1'b0, 32'h140, 32'h0, rd);
        check(rd, 32'h1);
        ahb(1'b1, 32'h180, dp, rd);
        ahb(1'b1, 32'h180, dp | 32'h10, rd);
        tick(1);
        check(32'(link_enable), 32'h1);
        wait_idle();
        check(32'(busy_len), 32'(len));
    endtask

    task automatic t_retrig();
        ahb(1'b1, 32'h140, 32'h8, rd);
        tick(15);
        ahb(1'b1, 32'h140, 32'h8, rd);
        // step off the edge so the counter's own update at this edge cannot undo the restart
        #1;
        busy_len = 0;
        wait_idle();
        check(32'(busy_len), 32'(FGT));
    endtask

    task automatic t_bg();
        ahb(1'b1, 32'h15C, 32'h3, rd);
        cal(32'h0, FGB);
        tick(2);
        check(32'(core_online[4] === 1'b1 && $countones(core_online) == 4), 32'h1);
        c0 = core_online;
        tick(ROUND / 5);
        check(32'(core_online[4] === 1'b1 && $countones(core_online) == 4), 32'h1);
        check(32'(core_online != c0), 32'h1);
        ahb(1'b1, 32'h140, 32'h8, rd);
        tick(1);
        check(32'(core_online), 32'h0F);
        ahb(1'b0, 32'h15C, 32'h0, rd);
        check(rd & 32'h3, 32'h3);
        ahb(1'b1, 32'h15C, 32'h0, rd);
        tick(2);
        check(32'(core_online), 32'h0F);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_sysref();
        t_sweep();
        t_bypass();
        t_ddc();
        t_ila();
        cal(32'h0, FG);
        cal(32'h8, FGT);
        t_retrig();
        t_bg();
        summarize();
    end
endmodule
`default_nettype wire
